/* verilog/eewc_top.sv */
// parallel EEPROM write controller: drives enables, address and data pins of the memory,
// detects end of write by data polling and toggle bit; the ready/busy line only shows in status
// assumes pins synchronous to sys_clk and an external pull-up on the ready/busy line
//
// How it works
// RULE1: status bits on data lines are valid only during a programming cycle.
// RULE2: internal write starts after the page-load timeout from the last byte.
// RULE3: polling bit reads inverted during the write, true after it.
// RULE4: alternating bit flips on each read during the write, first read zero.
// RULE5: write is over when alternating bit stops and real data returns.
// RULE6: page timer flag low while device awaits another page byte.
// RULE7: page timer flag high once the internal write starts.
// RULE8: write_done_n held low for the whole cycle, released after.
// RULE9: write_done_n goes low within 150 ns after the ending strobe.
// RULE10: standard 5 V write cycle ends within 3 ms.
// RULE11: fast 5 V write cycle ends within 1 ms.
// RULE12: low-voltage part: timeout at least 100 us, write within 5 ms.
// RULE13: page_select_bits stay the same on every strobe of a page.
// RULE14: write enable high between page strobes 50 ns to 1000 ns; the code times only the 56 ns minimum, the next strobe waits on software.
// RULE15: erase: chip enable low 1 us before write enable; pulse 10 ms.
// RULE16: erase: output enable 1 us before write enable rises; rearm within 3 ms.
// RULE17: completed chip erase leaves every byte reading all ones.
// RULE18: up to 64 bytes load in one page before the internal write.
// RULE19: no new array write until completion is seen.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module eewc_top
  import eewc_pkg::*;
#(
  parameter int ERASE_PULSE_CYC = ERASE_PULSE_CYC_DEF,
  parameter int ERASE_REARM_CYC = ERASE_REARM_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_oe_hv,
  output logic mem_we_n,
  output logic [12:0] mem_addr,
  input wire logic [7:0] mem_dq_in,
  output logic [7:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic write_done_n
);

  // ----------------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------------
  eewc_state_t state_q;
  eewc_state_t state_d;
  logic [20:0] cnt_q;
  logic [20:0] cnt_d;
  logic [2:0] cmd_pulse;
  logic [12:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [6:0] page_q;
  logic page_open_q;
  logic [6:0] nbytes_q;
  logic poll_true_q;
  logic [7:0] last_byte_q;
  logic alt_prev_q;
  logic have_prev_q;
  logic polling_q;
  logic erase_q;
  logic [EV_W-1:0] events;
  logic [7:0] status;
  logic busy;
  logic cmd_wr;
  logic cmd_rd;
  logic cmd_er;
  logic cmd_last;
  logic page_bad;
  logic cnt_done;
  logic poll_done;
  logic rd_sample;

  function automatic logic [20:0] cyc(input int n);
    cyc = 21'(n - 1);
  endfunction

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  eewc_ahb_regs u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .cmd_pulse(cmd_pulse),
    .addr_q(addr_reg),
    .wdata_q(wdata_reg),
    .rdata(rdata_q),
    .status(status),
    .events(events),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign busy = (state_q != EEWC_IDLE);
  assign cmd_wr = (cmd_pulse[1:0] == CMD_WRITE) && !busy;
  assign cmd_rd = (cmd_pulse[1:0] == CMD_READ) && !busy;
  assign cmd_er = (cmd_pulse[1:0] == CMD_ERASE) && !busy;
  assign cmd_last = cmd_pulse[CMD_LAST_BIT];
  // a byte for another page, or a 65th byte, is refused and the page stays open
  assign page_bad = cmd_wr && page_open_q &&
                    ((addr_reg[PAGE_HI:PAGE_LO] != page_q) ||
                     (nbytes_q == 7'(PAGE_BYTES))); // RULE13 RULE18
  assign cnt_done = (cnt_q == 21'h0);
  assign rd_sample = (state_q == EEWC_RD || state_q == EEWC_POLL) && cnt_done;
  // end of write: poll bit true and alternating bit stable across two reads
  assign poll_done = (mem_dq_in[BIT_POLL] == last_byte_q[BIT_POLL]) &&
                     have_prev_q && (mem_dq_in[BIT_ALT] == alt_prev_q); // RULE3 RULE4 RULE5
  assign rdata_d = rd_sample ? mem_dq_in : rdata_q;

  assign status = {busy, polling_q, page_open_q, !write_done_n, erase_q,
                   poll_true_q, 2'b00};

  assign events[EV_DONE] = busy && (state_d == EEWC_IDLE);
  assign events[EV_WDONE] = (state_q == EEWC_POLL) && rd_sample && poll_done;
  assign events[EV_REFUSED] = (cmd_pulse[1:0] != 2'h0) && busy;
  assign events[EV_PAGE] = page_bad;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 21'h1;
    unique case (state_q)
      EEWC_IDLE: begin
        if (cmd_wr && !page_bad && !polling_q) begin // RULE19
          state_d = EEWC_WLOW;
          cnt_d = cyc(STROBE_LOW_CYC);
        end else if (cmd_rd) begin
          state_d = polling_q ? EEWC_POLL : EEWC_RD;
          cnt_d = cyc(READ_CYC);
        end else if (cmd_er && !polling_q) begin
          state_d = EEWC_ESET;
          cnt_d = cyc(SETUP_CYC); // RULE15
        end
      end
      EEWC_WLOW: begin
        if (cnt_done) begin
          state_d = EEWC_WHIGH;
          cnt_d = cyc(STROBE_HIGH_CYC); // RULE14
        end
      end
      EEWC_WHIGH: begin
        if (cnt_done) begin
          state_d = EEWC_IDLE;
        end
      end
      EEWC_RD: begin
        if (cnt_done) begin
          state_d = EEWC_IDLE;
        end
      end
      EEWC_POLL: begin
        if (cnt_done) begin
          state_d = EEWC_IDLE;
        end
      end
      EEWC_ESET: begin
        if (cnt_done) begin
          state_d = EEWC_EPULSE;
          cnt_d = cyc(ERASE_PULSE_CYC); // RULE15
        end
      end
      EEWC_EPULSE: begin
        if (cnt_done) begin
          state_d = EEWC_EHOLD;
          cnt_d = cyc(SETUP_CYC); // RULE16
        end
      end
      EEWC_EHOLD: begin
        if (cnt_done) begin
          state_d = EEWC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= EEWC_IDLE;
      cnt_q <= 21'h0;
      rdata_q <= 8'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // page and write-cycle tracking
  // ----------------------------------------------------------------------
  // the page stays open until software marks the last byte; the device then
  // runs its own timeout and write, which only polling can see finish
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page_q <= 7'h0;
      page_open_q <= 1'b0;
      nbytes_q <= 7'h0;
      polling_q <= 1'b0;
      last_byte_q <= 8'h0;
      have_prev_q <= 1'b0;
      alt_prev_q <= 1'b0;
      poll_true_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      if (cmd_wr && !page_bad && !polling_q) begin
        page_q <= addr_reg[PAGE_HI:PAGE_LO];
        page_open_q <= !cmd_last;
        nbytes_q <= page_open_q ? nbytes_q + 7'h1 : 7'h1;
        last_byte_q <= wdata_reg; // RULE3
        polling_q <= cmd_last; // RULE2 RULE6 RULE7
        have_prev_q <= 1'b0;
        poll_true_q <= 1'b0;
      end
      if (cmd_er && !polling_q) begin
        erase_q <= 1'b1;
        last_byte_q <= 8'hff; // RULE17
      end
      if (state_q == EEWC_EHOLD && cnt_done) begin
        erase_q <= 1'b0;
        polling_q <= 1'b1;
        have_prev_q <= 1'b0;
        poll_true_q <= 1'b0;
      end
      if (events[EV_WDONE]) begin
        polling_q <= 1'b0; // RULE1 RULE8
        poll_true_q <= 1'b1;
      end else if (state_q == EEWC_POLL && rd_sample) begin
        have_prev_q <= 1'b1;
        alt_prev_q <= mem_dq_in[BIT_ALT]; // RULE4
      end
    end
  end

  // ----------------------------------------------------------------------
  // pins, all from flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_oe_hv <= 1'b0;
      mem_we_n <= 1'b1;
      mem_addr <= 13'h0;
      mem_dq_out <= 8'h0;
      mem_dq_oe <= 1'b0;
    end else begin
      mem_ce_n <= !(state_d == EEWC_WLOW || state_d == EEWC_RD || state_d == EEWC_POLL ||
                    state_d == EEWC_ESET || state_d == EEWC_EPULSE);
      mem_oe_n <= !(state_d == EEWC_RD || state_d == EEWC_POLL);
      mem_oe_hv <= (state_d == EEWC_ESET || state_d == EEWC_EPULSE); // RULE16
      mem_we_n <= !(state_d == EEWC_WLOW || state_d == EEWC_EPULSE);
      mem_dq_oe <= (state_d == EEWC_WLOW);
      if (cmd_wr || cmd_rd) begin
        mem_addr <= addr_reg;
        mem_dq_out <= wdata_reg;
      end
    end
  end

endmodule

/* verilog/eewc_pkg.sv */
// package for the parallel EEPROM write controller: register map, pin timing, states
// assumes a 125 MHz sys_clk; all counts derive from the times below
package eewc_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STROBE_LOW_NS = 50;          // least strobe low width
  localparam int STROBE_HIGH_NS = 50;         // least gap between page strobes
  localparam int STROBE_HIGH_MAX_NS = 1000;   // longest gap between page strobes
  localparam int BUSY_DELAY_NS = 150;         // strobe_to_busy_delay
  localparam int SETUP_US = 1;                // erase enable-to-strobe setups
  localparam int ERASE_PULSE_MS = 10;
  localparam int ERASE_REARM_MS = 3;
  localparam int READ_ACCESS_NS = 150;        // read access allowance
  localparam int PAGE_BYTES = 64;

  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_HIGH_MAX_CYC = (STROBE_HIGH_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int BUSY_DELAY_CYC = (BUSY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // erase pulse is 1250000 cycles and rearm 375000: top-level parameters
  localparam int ERASE_PULSE_CYC_DEF = ERASE_PULSE_MS * 125000;
  localparam int ERASE_REARM_CYC_DEF = ERASE_REARM_MS * 125000;

  // ----------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;     // write: start command
  localparam logic [7:0] REG_ADDR = 8'h04;    // array address
  localparam logic [7:0] REG_WDATA = 8'h08;   // byte to write
  localparam logic [7:0] REG_RDATA = 8'h0c;   // last byte read
  localparam logic [7:0] REG_STAT = 8'h10;    // live state
  localparam logic [7:0] REG_IRQ = 8'h14;     // sticky events, write 1 clears
  localparam logic [7:0] REG_MASK = 8'h18;    // interrupt mask

  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_ERASE = 2'h3;
  localparam int CMD_LAST_BIT = 2;            // cmd bit 2: last byte of page

  // sticky event bits
  localparam int EV_DONE = 0;                 // operation finished
  localparam int EV_WDONE = 1;                // internal write completed
  localparam int EV_REFUSED = 2;              // command refused while busy
  localparam int EV_PAGE = 3;                 // page crossing refused
  localparam int EV_W = 4;

  localparam int BIT_POLL = 7;
  localparam int BIT_ALT = 6;
  localparam int BIT_TIMER = 5;
  localparam int PAGE_HI = 12;
  localparam int PAGE_LO = 6;

  typedef enum logic [7:0] {
    EEWC_IDLE = 8'h01,
    EEWC_WLOW = 8'h02,
    EEWC_WHIGH = 8'h04,
    EEWC_RD = 8'h08,
    EEWC_POLL = 8'h10,
    EEWC_ESET = 8'h20,
    EEWC_EPULSE = 8'h40,
    EEWC_EHOLD = 8'h80
  } eewc_state_t;

endpackage

/* verilog/eewc_ahb_regs.sv */
// AHB-Lite slave holding the controller's own registers
// assumes a single master doing whole-word single transfers; always OKAY, no wait states
`timescale 1ns/10ps
module eewc_ahb_regs
  import eewc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [2:0] cmd_pulse,
  output logic [12:0] addr_q,
  output logic [7:0] wdata_q,
  input wire logic [7:0] rdata,
  input wire logic [7:0] status,
  input wire logic [EV_W-1:0] events,
  output logic irq
);

  // ----------------------------------------------------------------------
  // address phase capture
  // ----------------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [EV_W-1:0] irq_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] irq_d;
  logic [31:0] rd_mux;
  logic take;
  logic wr_cmd;
  logic wr_irq;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_cmd = wr_pend_q && (wr_addr_q == REG_CMD);
  assign wr_irq = wr_pend_q && (wr_addr_q == REG_IRQ);
  assign cmd_pulse = wr_cmd ? hwdata[2:0] : 3'h0;
  // a new event wins over a write-one clear in the same cycle
  assign irq_d = (irq_q & ~(wr_irq ? hwdata[EV_W-1:0] : {EV_W{1'b0}})) | events;
  assign irq = |(irq_q & mask_q);

  assign rd_mux = (haddr[7:0] == REG_ADDR) ? {19'h0, addr_q} :
                  (haddr[7:0] == REG_WDATA) ? {24'h0, wdata_q} :
                  (haddr[7:0] == REG_RDATA) ? {24'h0, rdata} :
                  (haddr[7:0] == REG_STAT) ? {24'h0, status} :
                  (haddr[7:0] == REG_IRQ) ? {28'h0, irq_q} :
                  (haddr[7:0] == REG_MASK) ? {28'h0, mask_q} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata <= 32'h0;
    end else begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr[7:0];
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_q <= 13'h0;
      wdata_q <= 8'h0;
      mask_q <= {EV_W{1'b0}};
      irq_q <= {EV_W{1'b0}};
    end else begin
      irq_q <= irq_d;
      if (wr_pend_q && wr_addr_q == REG_ADDR) begin
        addr_q <= hwdata[12:0];
      end
      if (wr_pend_q && wr_addr_q == REG_WDATA) begin
        wdata_q <= hwdata[7:0];
      end
      if (wr_pend_q && wr_addr_q == REG_MASK) begin
        mask_q <= hwdata[EV_W-1:0];
      end
    end
  end

endmodule

/* tb/eewc_top_assertions.sv */
// pin and bus checker for the parallel EEPROM write controller
// sees only eewc_top ports; bound at the foot of this file
`timescale 1ns/10ps
module eewc_top_assertions #(
  parameter int ERASE_PULSE_CYC = 20,
  parameter int ERASE_REARM_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_oe_hv,
  input wire logic mem_we_n,
  input wire logic [12:0] mem_addr,
  input wire logic [7:0] mem_dq_out,
  input wire logic mem_dq_oe
);
  // ----------------------------------------------------------------------
  // strobe low counter
  // ----------------------------------------------------------------------
  int lo_q;
  always_ff @(posedge sys_clk) begin
    if (rst || mem_we_n) lo_q <= 0;
    else lo_q <= lo_q + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready and okay");
  property p_strobe_low;
    // erase drops the high voltage on the same edge as the strobe rises
    $rose(mem_we_n) && !$past(mem_oe_hv) |-> lo_q == 7;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("write strobe width");
  property p_strobe_gap;
    $rose(mem_we_n) && !$past(mem_oe_hv) |-> mem_we_n [*7];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe gap short");
  property p_page_hold;
    !mem_we_n && !$past(mem_we_n) |-> $stable(mem_addr) && $stable(mem_dq_out);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("address moved in strobe");
  property p_write_mode;
    !mem_we_n && !mem_oe_hv |-> !mem_ce_n && mem_oe_n && mem_dq_oe;
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("bad write pin mix");
  property p_read_mode;
    !mem_oe_n |-> !mem_dq_oe && mem_we_n;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("data driven during read");
  property p_erase_setup;
    $fell(mem_we_n) && mem_oe_hv |-> !$past(mem_ce_n, 125) && $past(mem_oe_hv, 125);
  endproperty
  a_erase_setup: assert property (p_erase_setup) else $error("erase setup short");
  property p_erase_len;
    $rose(mem_we_n) && $past(mem_oe_hv) |-> lo_q >= ERASE_PULSE_CYC;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase pulse short");
  property p_erase_hold;
    !mem_we_n && $past(mem_oe_hv) |-> mem_oe_hv && !mem_ce_n;
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase voltage dropped");

  c_write: cover property ($rose(mem_we_n) && !$past(mem_oe_hv));
  c_erase: cover property ($rose(mem_we_n) && $past(mem_oe_hv));
  c_read: cover property ($fell(mem_oe_n));
endmodule

bind eewc_top eewc_top_assertions #(.ERASE_PULSE_CYC(ERASE_PULSE_CYC),
  .ERASE_REARM_CYC(ERASE_REARM_CYC)) u_eewc_top_assertions (.sys_clk, .rst, .hreadyout,
  .hresp, .mem_ce_n, .mem_oe_n, .mem_oe_hv, .mem_we_n, .mem_addr, .mem_dq_out, .mem_dq_oe);

/* tb/eewc_mem_model.sv */
// behavioural parallel EEPROM: page timer, polling, toggle and ready/busy
// assumes pins change just after sys_clk edges; times shortened for simulation
`timescale 1ns/10ps
module eewc_mem_model #(
  parameter int TMO = 200,
  parameter int TWC = 300,
  parameter int EP = 20
) (
  input wire logic sys_clk,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_oe_hv,
  input wire logic mem_we_n,
  input wire logic [12:0] mem_addr,
  input wire logic [7:0] mem_dq_out,
  input wire logic mem_dq_oe,
  output logic [7:0] mem_dq_in,
  output logic write_done_n
);
  logic [7:0] mem [0:8191];
  logic [7:0] ld, val;
  logic [12:0] la;
  logic last7, tog, bad, rd_q, wr_q;
  int tmr, wc, elo, n;
  logic [12:0] qa [$];
  logic [7:0] qd [$];
  wire rd = !mem_ce_n && !mem_oe_n && !mem_oe_hv && mem_we_n;
  wire wr = !mem_ce_n && !mem_we_n && mem_oe_n && !mem_oe_hv && mem_dq_oe;
  wire er = !mem_ce_n && !mem_we_n && mem_oe_hv;
  initial begin
    foreach (mem[k]) mem[k] = 8'hff;
    {last7, tog, bad, rd_q, wr_q} = 5'h00;
    tmr = 0;
    wc = 0;
    elo = 0;
    val = 8'h00;
    mem_dq_in = 8'h00;
    write_done_n = 1'b1;
  end
  always @(posedge sys_clk) begin
    if (wr) begin
      la = mem_addr;
      ld = mem_dq_out;
    end
    if (wr_q && !wr && wc == 0) begin
      // a byte from a foreign page spoils the whole load
      if (qa.size() > 0 && qa[0][12:6] != la[12:6]) bad = 1'b1;
      qa.push_back(la);
      qd.push_back(ld);
      if (tmr == 0) tog = 1'b0;
      last7 = ld[7];
      tmr = TMO;
    end else if (tmr > 0) begin
      tmr--;
      if (tmr == 0) begin
        for (n = 0; n < qa.size(); n++) if (!bad && n < 64) mem[qa[n]] = qd[n];
        qa.delete();
        qd.delete();
        bad = 1'b0;
        wc = TWC;
      end
    end else if (wc > 0) wc--;
    if (er) elo++;
    else begin
      if (elo >= EP) begin
        foreach (mem[k]) mem[k] = 8'hff;
        last7 = 1'b1;
        tog = 1'b0;
        wc = TWC;
      end
      elo = 0;
    end
    if (rd && !rd_q) begin
      if (tmr > 0 || wc > 0) begin
        val = {~last7, tog, wc > 0, ~val[4:0]};
        tog = ~tog;
      end else val = mem[mem_addr];
    end
    rd_q = rd;
    wr_q = wr;
    // released lines wander so a stale value never looks valid
    mem_dq_in <= rd ? val : ~mem_dq_in;
    write_done_n <= !(tmr > 0 || wc > 0 || er);
  end
endmodule

/* tb/eewc_top_bench.sv */
// self-checking bench: AHB-Lite master tasks drive the controller against the memory model
// assumes a 125 MHz clock and a shortened erase pulse
`timescale 1ns/10ps
module eewc_top_bench;
  import eewc_pkg::*;
  logic sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ce_n, oe_n, oe_hv, we_n, dq_oe, rdn;
  logic [12:0] ma;
  logic [7:0] dqi, dqo;
  int fail_count, n_compared;
  assign hready = hreadyout;

  eewc_top #(.ERASE_PULSE_CYC(20), .ERASE_REARM_CYC(10)) u_eewc_top (.sys_clk(sys_clk),
    .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_oe_hv(oe_hv), .mem_we_n(we_n),
    .mem_addr(ma), .mem_dq_in(dqi), .mem_dq_out(dqo), .mem_dq_oe(dq_oe), .write_done_n(rdn));
  eewc_mem_model #(.TMO(200), .TWC(300), .EP(20)) u_eewc_mem_model (.sys_clk(sys_clk),
    .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_oe_hv(oe_hv), .mem_we_n(we_n), .mem_addr(ma),
    .mem_dq_out(dqo), .mem_dq_oe(dq_oe), .mem_dq_in(dqi), .write_done_n(rdn));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", n, exp, got);
      fail_count++;
    end
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0, v);
    chk(n, v & m, e);
  endtask
  task automatic idle;
    for (int k = 0; k < 400; k++) begin
      bus(1'b0, REG_STAT, 32'h0, v);
      if (v[7] === 1'b0) break;
    end
    chk("idle", {31'h0, v[7]}, 32'h0);
  endtask
  task automatic op(input logic [2:0] c, input logic [12:0] a, input logic [7:0] d);
    wr(REG_ADDR, {19'h0, a});
    wr(REG_WDATA, {24'h0, d});
    wr(REG_CMD, {29'h0, c});
    idle();
  endtask
  task automatic poll(input logic [12:0] a);
    for (int k = 0; k < 60; k++) begin
      op({1'b0, CMD_READ}, a, 8'h00);
      bus(1'b0, REG_STAT, 32'h0, v);
      if (v[6] === 1'b0) break;
    end
    chk("poll_end", {31'h0, v[6]}, 32'h0);
  endtask
  task automatic back(input logic [12:0] a, input logic [7:0] e);
    op({1'b0, CMD_READ}, a, 8'h00);
    rdchk("rdata", REG_RDATA, 32'hff, {24'h0, e});
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 1'b1, 1'b0, 2'h0, 64'h0, 3'h2};
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk("status", REG_STAT, 32'hffffffff, 32'h0);
    rdchk("irq_reg", REG_IRQ, 32'hffffffff, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rdchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    $display("test reset done");
    wr(REG_MASK, 32'h2);
    op({1'b0, CMD_WRITE}, 13'h0c0, 8'ha5);
    op({1'b0, CMD_WRITE}, 13'h0c1, 8'h3c);
    op({1'b1, CMD_WRITE}, 13'h0c2, 8'h81);
    op({1'b0, CMD_READ}, 13'h0c2, 8'h00);
    rdchk("poll1", REG_RDATA, 32'he0, 32'h00);
    op({1'b0, CMD_READ}, 13'h0c2, 8'h00);
    rdchk("poll2", REG_RDATA, 32'he0, 32'h40);
    repeat (220) @(posedge sys_clk);
    op({1'b0, CMD_READ}, 13'h0c2, 8'h00);
    rdchk("poll3", REG_RDATA, 32'he0, 32'h20);
    rdchk("busy_pin", REG_STAT, 32'h50, 32'h50);
    op({1'b1, CMD_WRITE}, 13'h0c5, 8'h11);
    wr(REG_CMD, {30'h0, CMD_READ});
    wr(REG_CMD, {30'h0, CMD_READ});
    idle();
    rdchk("refused", REG_IRQ, 32'h4, 32'h4);
    poll(13'h0c2);
    rdchk("poll_ok", REG_STAT, 32'h14, 32'h04);
    rdchk("wdone", REG_IRQ, 32'h2, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(REG_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(REG_IRQ, 32'hf);
    rdchk("irq_clear", REG_IRQ, 32'hf, 32'h0);
    back(13'h0c0, 8'ha5);
    rdchk("op_done", REG_IRQ, 32'h1, 32'h1);
    back(13'h0c1, 8'h3c);
    back(13'h0c2, 8'h81);
    back(13'h0c5, 8'hff);
    $display("test page write done");
    op({1'b0, CMD_ERASE}, 13'h0, 8'h00);
    poll(13'h0);
    back(13'h0c1, 8'hff);
    $display("test erase done");
    op({1'b0, CMD_WRITE}, 13'h100, 8'h12);
    op({1'b0, CMD_WRITE}, 13'h140, 8'h34);
    rdchk("crossing", REG_IRQ, 32'h8, 32'h8);
    op({1'b1, CMD_WRITE}, 13'h101, 8'h56);
    poll(13'h101);
    back(13'h100, 8'h12);
    back(13'h101, 8'h56);
    back(13'h140, 8'hff);
    $display("test page crossing done");
    complete_run();
  end
endmodule
